/* File: frbg_defines.vh */
`ifndef FRBG_DEFINES_VH
`define FRBG_DEFINES_VH
// Flash command codes (two-step write/erase)
`define FRBG_CMD_PROGRAM      8'h40
`define FRBG_CMD_ERASE_SETUP  8'h20
`define FRBG_CMD_ERASE_CONF   8'hD0
`define FRBG_CMD_SUSPEND      8'hB0
`define FRBG_CMD_RESUME       8'hD0
`define FRBG_CMD_READ_STATUS  8'h70
`define FRBG_CMD_CLEAR_STATUS 8'h50
`define FRBG_CMD_READ_ARRAY   8'hFF
// Status register fields
`define FRBG_SR_READY_BIT     7
`define FRBG_SR_VPP_LOW_BIT   3
// Operation codes on the host command port
`define FRBG_OP_PROGRAM       2'h0
`define FRBG_OP_ERASE         2'h1
`define FRBG_OP_SUSPEND       2'h2
`define FRBG_OP_STATUS        2'h3
// Timing, ns and derived cycles at 5 ns
`define FRBG_CLK_NS           5
`define FRBG_WE_PULSE_NS      40
`define FRBG_WE_PULSE_CYC     ((`FRBG_WE_PULSE_NS + `FRBG_CLK_NS - 1) / `FRBG_CLK_NS)
`define FRBG_VPP_SETTLE_NS    100
`define FRBG_VPP_SETTLE_CYC   ((`FRBG_VPP_SETTLE_NS + `FRBG_CLK_NS - 1) / `FRBG_CLK_NS)
`define FRBG_WAKE_NS          1000
`define FRBG_WAKE_CYC         ((`FRBG_WAKE_NS + `FRBG_CLK_NS - 1) / `FRBG_CLK_NS)
`define FRBG_NUM_DEV          4
`endif

/* File: frbg_merge.v */
`timescale 1ns/1ps
`default_nettype none
module frbg_merge (
  input  wire       ref_clk_in,
  input  wire       nrst_in,
  input  wire [3:0] ready_busy_n_in,
  input  wire [3:0] active_in,
  output reg        all_ready_out,
  output reg  [3:0] ready_rise_out,
  output reg  [3:0] ready_level_out
);
  reg [3:0] prev;
  always @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      all_ready_out   <= 1'b1;
      ready_rise_out  <= 4'h0;
      ready_level_out <= 4'hF;
      prev            <= 4'hF;
    end else begin
      all_ready_out   <= &ready_busy_n_in;
      ready_level_out <= ready_busy_n_in;
      prev            <= ready_busy_n_in;
      ready_rise_out  <= ready_busy_n_in & ~prev & active_in;
    end
  end
endmodule
`default_nettype wire

/* File: frbg_host.v */
`timescale 1ns/1ps
`default_nettype none
`include "frbg_defines.vh"
module frbg_host (
  input  wire        ref_clk_in,
  input  wire        nrst_in,
  input  wire        cmd_valid_in,
  input  wire [1:0]  cmd_op_in,
  input  wire [1:0]  cmd_dev_in,
  input  wire [19:0] cmd_addr_in,
  input  wire [7:0]  cmd_data_in,
  input  wire        sleep_req_in,
  input  wire        irq_mask_in,
  input  wire [3:0]  ready_busy_n_in,
  input  wire [7:0]  flash_data_in,
  output reg         cmd_ready_out,
  output reg         done_out,
  output reg  [7:0]  status_out,
  output reg  [1:0]  done_dev_out,
  output reg         irq_out,
  output reg         merged_ready_out,
  output reg  [3:0]  ready_level_out,
  output reg  [3:0]  active_out,
  output reg  [19:0] flash_addr_out,
  output reg  [7:0]  flash_data_out,
  output reg         flash_data_oe_out,
  output reg  [3:0]  chip_en_n_out,
  output reg         write_en_n_out,
  output reg         out_en_n_out,
  output reg         vpp_en_out,
  output reg         deep_sleep_n_out
);
  localparam ST_IDLE  = 3'd0;
  localparam ST_VPP   = 3'd1;
  localparam ST_WR1   = 3'd2;
  localparam ST_WR2   = 3'd3;
  localparam ST_WAIT  = 3'd4;
  localparam ST_POLL  = 3'd5;
  localparam ST_WAKE  = 3'd6;
  localparam ST_SLEEP = 3'd7;

  localparam integer VPP_LAST_I  = `FRBG_VPP_SETTLE_CYC - 1;
  localparam integer WE_LAST_I   = `FRBG_WE_PULSE_CYC - 1;
  localparam integer WAKE_LAST_I = `FRBG_WAKE_CYC - 1;
  localparam [7:0]   VPP_LAST    = VPP_LAST_I[7:0];
  localparam [7:0]   WE_LAST     = WE_LAST_I[7:0];
  localparam [7:0]   WAKE_LAST   = WAKE_LAST_I[7:0];

  function [7:0] first_code;
    input [1:0] op;
    begin
      case (op)
        `FRBG_OP_PROGRAM: first_code = `FRBG_CMD_PROGRAM;
        `FRBG_OP_ERASE:   first_code = `FRBG_CMD_ERASE_SETUP;
        `FRBG_OP_SUSPEND: first_code = `FRBG_CMD_SUSPEND;
        default:          first_code = `FRBG_CMD_READ_STATUS;
      endcase
    end
  endfunction

  function [3:0] dev_sel;
    input [1:0] d;
    begin
      dev_sel = 4'h1 << d;
    end
  endfunction

  wire       all_ready;
  wire [3:0] ready_rise;
  wire [3:0] ready_level;

  frbg_merge u_merge (
    .ref_clk_in      (ref_clk_in),
    .nrst_in         (nrst_in),
    .ready_busy_n_in (ready_busy_n_in),
    .active_in       (active_out),
    .all_ready_out   (all_ready),
    .ready_rise_out  (ready_rise),
    .ready_level_out (ready_level)
  );

  reg [2:0]  state;
  reg [7:0]  cnt;
  reg [1:0]  op;
  reg [1:0]  dev;
  reg [19:0] addr;
  reg [7:0]  data;
  reg        step;
  reg        poll_all;

  always @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      state             <= ST_WAKE;
      cnt               <= 8'h00;
      op                <= 2'h0;
      dev               <= 2'h0;
      addr              <= 20'h00000;
      data              <= 8'h00;
      step              <= 1'b0;
      poll_all          <= 1'b0;
      cmd_ready_out     <= 1'b0;
      done_out          <= 1'b0;
      status_out        <= 8'h00;
      done_dev_out      <= 2'h0;
      irq_out           <= 1'b0;
      merged_ready_out  <= 1'b1;
      ready_level_out   <= 4'hF;
      active_out        <= 4'h0;
      flash_addr_out    <= 20'h00000;
      flash_data_out    <= 8'h00;
      flash_data_oe_out <= 1'b0;
      chip_en_n_out     <= 4'hF;
      write_en_n_out    <= 1'b1;
      out_en_n_out      <= 1'b1;
      vpp_en_out        <= 1'b0;
      deep_sleep_n_out  <= 1'b1;
    end else begin
      done_out         <= 1'b0;
      merged_ready_out <= all_ready;
      ready_level_out  <= ready_level;
      irq_out          <= (|ready_rise) & ~irq_mask_in;
      case (state)
        ST_IDLE: begin
          cmd_ready_out <= 1'b1;
          // Only a request seen while ready is shown is taken
          if (cmd_valid_in && cmd_ready_out) begin
            cmd_ready_out <= 1'b0;
            op            <= cmd_op_in;
            dev           <= cmd_dev_in;
            addr          <= cmd_addr_in;
            data          <= cmd_data_in;
            step          <= 1'b0;
            cnt           <= 8'h00;
            if (cmd_op_in == `FRBG_OP_PROGRAM || cmd_op_in == `FRBG_OP_ERASE) begin
              vpp_en_out <= 1'b1;
              state      <= ST_VPP;
            end else begin
              state <= ST_WR1;
            end
          end else if (sleep_req_in) begin
            cmd_ready_out    <= 1'b0;
            deep_sleep_n_out <= 1'b0;
            state            <= ST_SLEEP;
          end else if (poll_all && active_out != 4'h0) begin
            cmd_ready_out <= 1'b0;
            poll_all      <= 1'b0;
            dev           <= active_out[0] ? 2'd0 : active_out[1] ? 2'd1 : active_out[2] ? 2'd2 : 2'd3;
            op            <= `FRBG_OP_STATUS;
            step          <= 1'b0;
            cnt           <= 8'h00;
            state         <= ST_WR1;
          end
        end
        ST_VPP: begin
          cnt <= cnt + 8'h01;
          if (cnt == VPP_LAST) begin
            cnt   <= 8'h00;
            state <= ST_WR1;
          end
        end
        ST_WR1: begin
          chip_en_n_out     <= ~dev_sel(dev);
          flash_addr_out    <= addr;
          flash_data_oe_out <= 1'b1;
          flash_data_out    <= step ? ((op == `FRBG_OP_ERASE) ? `FRBG_CMD_ERASE_CONF : data)
                                    : first_code(op);
          write_en_n_out    <= 1'b0;
          cnt               <= cnt + 8'h01;
          if (cnt == WE_LAST) begin
            write_en_n_out <= 1'b1;
            cnt            <= 8'h00;
            state          <= ST_WR2;
          end
        end
        ST_WR2: begin
          chip_en_n_out     <= 4'hF;
          flash_data_oe_out <= 1'b0;
          if (!step && (op == `FRBG_OP_PROGRAM || op == `FRBG_OP_ERASE)) begin
            step  <= 1'b1;
            state <= ST_WR1;
          end else if (op == `FRBG_OP_STATUS) begin
            chip_en_n_out <= ~dev_sel(dev);
            out_en_n_out  <= 1'b0;
            state         <= ST_POLL;
          end else begin
            if (op == `FRBG_OP_PROGRAM || op == `FRBG_OP_ERASE)
              active_out <= active_out | dev_sel(dev);
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          cnt <= cnt + 8'h01;
          if (cnt == WE_LAST) begin
            cnt           <= 8'h00;
            done_out      <= 1'b1;
            done_dev_out  <= dev;
            state         <= ST_IDLE;
          end
        end
        ST_POLL: begin
          cnt <= cnt + 8'h01;
          if (cnt == WE_LAST) begin
            cnt           <= 8'h00;
            chip_en_n_out <= 4'hF;
            out_en_n_out  <= 1'b1;
            status_out    <= flash_data_in;
            done_out      <= 1'b1;
            done_dev_out  <= dev;
            if (flash_data_in[`FRBG_SR_READY_BIT]) begin
              active_out <= active_out & ~dev_sel(dev);
              poll_all   <= |(active_out & ~dev_sel(dev));
              if ((active_out & ~dev_sel(dev)) == 4'h0)
                vpp_en_out <= 1'b0;
            end
            state <= ST_IDLE;
          end
        end
        ST_SLEEP: begin
          vpp_en_out <= 1'b0;
          if (!sleep_req_in) begin
            deep_sleep_n_out <= 1'b1;
            cnt              <= 8'h00;
            state            <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          cnt <= cnt + 8'h01;
          if (cnt == WAKE_LAST) begin
            cnt   <= 8'h00;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
      // New completion beats a clear in the same cycle
      if (|ready_rise)
        poll_all <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: frbg_host_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module frbg_host_assertions (
  input wire logic       ref_clk_in,
  input wire logic       nrst_in,
  input wire logic [3:0] ready_busy_n_in,
  input wire logic       irq_mask_in,
  input wire logic       irq_out,
  input wire logic       merged_ready_out,
  input wire logic [3:0] ready_level_out,
  input wire logic [3:0] chip_en_n_out,
  input wire logic       write_en_n_out,
  input wire logic [7:0] flash_data_out,
  input wire logic       flash_data_oe_out,
  input wire logic       vpp_en_out,
  input wire logic       deep_sleep_n_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  merge_all_a: assert property ($past(nrst_in) && $past(nrst_in, 2) |-> merged_ready_out == &$past(ready_busy_n_in, 2))
    else $error("merged ready wrong");
  level_each_a: assert property ($past(nrst_in) && $past(nrst_in, 2) |-> ready_level_out == $past(ready_busy_n_in, 2))
    else $error("ready level wrong");
  data_drive_a: assert property (!write_en_n_out |-> flash_data_oe_out && chip_en_n_out != 4'hF)
    else $error("write strobe without data drive");
  irq_pulse_a: assert property (irq_out |=> !irq_out)
    else $error("irq too long");
  irq_mask_a: assert property (irq_mask_in [*3] |-> !irq_out)
    else $error("masked irq seen");
  prog_pair_a: assert property (
    $fell(write_en_n_out) && flash_data_out == 8'h40 |-> ##[9:40] $fell(write_en_n_out))
    else $error("program lacks second step");
  erase_pair_a: assert property (
    $fell(write_en_n_out) && flash_data_out == 8'h20 |-> ##[9:40] ($fell(write_en_n_out) && flash_data_out == 8'hD0))
    else $error("erase lacks confirm");
  vpp_guard_a: assert property (!write_en_n_out && flash_data_out inside {8'h40, 8'h20} |-> vpp_en_out)
    else $error("write without supply");
  sleep_quiet_a: assert property (!deep_sleep_n_out |-> write_en_n_out && chip_en_n_out == 4'hF)
    else $error("access during sleep");
  cover property (irq_out);
  cover property (!deep_sleep_n_out);
  cover property (!merged_ready_out);
endmodule
`default_nettype wire

/* File: frbg_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module frbg_flash_model #(
  parameter int BUSY = 120
) (
  input  wire logic       clk_in,
  input  wire logic [3:0] ce_n_in,
  input  wire logic       we_n_in,
  input  wire logic       oe_n_in,
  input  wire logic       vpp_ok_in,
  input  wire logic       deep_sleep_n_in,
  input  wire logic [7:0] data_in,
  output var  logic [7:0] data_out,
  output var  logic [3:0] ready_busy_n_out
);
  logic [7:0] step [4] = '{default: 8'h00};
  logic [7:0] lat_d;
  logic [3:0] lat_ce;
  logic [3:0] vlow = 4'h0;
  logic       we_q = 1'b1;
  int         cnt [4] = '{default: 0};
  initial ready_busy_n_out = 4'hF;
  initial data_out = 8'h00;
  always @(posedge clk_in) begin
    we_q <= we_n_in;
    if (!we_n_in) begin
      lat_d <= data_in;
      lat_ce <= ce_n_in;
    end
    // Released bus toggles
    data_out <= ~data_out;
    for (int i = 0; i < 4; i++) begin
      if (cnt[i] == 1) ready_busy_n_out[i] <= 1'b1;
      if (cnt[i] > 0) cnt[i] <= cnt[i] - 1;
      if (!ce_n_in[i] && !oe_n_in && deep_sleep_n_in) data_out <= {ready_busy_n_out[i], 3'h0, vlow[i], 3'h0};
      if (we_n_in && !we_q && !lat_ce[i] && deep_sleep_n_in) begin
        if (step[i] == 8'h40 || (step[i] == 8'h20 && lat_d == 8'hD0)) begin
          step[i] <= 8'h00;
          if (vpp_ok_in) begin
            ready_busy_n_out[i] <= 1'b0;
            cnt[i] <= BUSY;
          end else vlow[i] <= 1'b1;
        end else begin
          step[i] <= lat_d;
          if (lat_d == 8'hB0) cnt[i] <= 1;
        end
      end
    end
    if (!deep_sleep_n_in) begin
      ready_busy_n_out <= 4'hF;
      cnt <= '{default: 0};
    end
  end
endmodule
`default_nettype wire

/* File: frbg_host_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "frbg_defines.vh"
module frbg_host_bench;
  logic        ref_clk_in, nrst_in, cmd_valid_in, sleep_req_in, irq_mask_in, vpp_fail;
  logic [1:0]  cmd_op_in, cmd_dev_in;
  logic [19:0] cmd_addr_in;
  logic [7:0]  cmd_data_in;
  wire  [7:0]  flash_data_in, status_out, flash_data_out;
  wire  [3:0]  ready_busy_n_in, ready_level_out, active_out, chip_en_n_out;
  wire  [19:0] flash_addr_out;
  wire  [1:0]  done_dev_out;
  wire         cmd_ready_out, done_out, irq_out, merged_ready_out, flash_data_oe_out;
  wire         write_en_n_out, out_en_n_out, vpp_en_out, deep_sleep_n_out;
  logic [7:0]  note_q [$];
  int          miscompares = 0;
  int          samples_checked = 0;
  frbg_host dut (.*);
  frbg_flash_model #(.BUSY(120)) flash (.clk_in(ref_clk_in), .ce_n_in(chip_en_n_out), .we_n_in(write_en_n_out),
    .oe_n_in(out_en_n_out), .vpp_ok_in(vpp_en_out && !vpp_fail), .deep_sleep_n_in(deep_sleep_n_out),
    .data_in(flash_data_out), .data_out(flash_data_in), .ready_busy_n_out(ready_busy_n_in));
  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end
  task automatic final_report();
    if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Waits: 0 done, 1 irq, 2 ready
  task automatic waitc(input int sel);
    logic [2:0] s;
    for (int n = 0; n < 2000; n++) begin
      @(posedge ref_clk_in);
      s = {cmd_ready_out, irq_out, done_out};
      if (s[sel] === 1'b1) return;
    end
    miscompares++;
    final_report();
  endtask
  task automatic issue(input logic [1:0] op, input logic [1:0] dev);
    cmd_op_in <= op;
    cmd_dev_in <= dev;
    cmd_addr_in <= 20'($urandom);
    cmd_data_in <= {3'h4, 5'($urandom)};
    cmd_valid_in <= 1'b1;
    waitc(2);
    cmd_valid_in <= 1'b0;
    waitc(0);
    chk("flash_addr_out", cmd_addr_in, flash_addr_out);
  endtask
  always @(posedge ref_clk_in)
    if (done_out === 1'b1 && note_q.size() > 0) chk("status_out", note_q.pop_front(), status_out);
  initial begin
    {nrst_in, cmd_valid_in, sleep_req_in, irq_mask_in, vpp_fail, cmd_op_in, cmd_dev_in} = '0;
    cmd_addr_in = 20'h00000;
    cmd_data_in = 8'h00;
    void'($urandom(86));
    repeat (16) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    waitc(2);
    chk("ready_level_out", 8'h0F, {4'h0, ready_level_out});
    for (int d = 0; d < 4; d++) begin
      issue(2'(d & 1), 2'(d));
      chk("busy_level", 8'h00, {7'h0, ready_level_out[d]});
      chk("active_out", 20'(1 << d), {16'h0, active_out & (4'h1 << d)});
      chk("merged_ready_out", 8'h00, {7'h0, merged_ready_out});
      waitc(1);
      repeat (40) @(posedge ref_clk_in);
      note_q.push_back(8'h80);
      issue(`FRBG_OP_STATUS, 2'(d));
      chk("done_dev_out", 20'(d), {18'h0, done_dev_out});
      chk("vpp_en_out", 20'h0, {19'h0, vpp_en_out});
    end
    issue(`FRBG_OP_ERASE, 2'h2);
    irq_mask_in <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    issue(`FRBG_OP_SUSPEND, 2'h2);
    repeat (30) begin
      @(posedge ref_clk_in);
      if (irq_out === 1'b1) chk("masked_irq", 8'h00, 8'h01);
    end
    chk("suspend_level", 8'h04, {4'h0, ready_level_out & 4'h4});
    irq_mask_in <= 1'b0;
    sleep_req_in <= 1'b1;
    repeat (8) @(posedge ref_clk_in);
    chk("deep_sleep_n_out", 8'h00, {7'h0, deep_sleep_n_out});
    chk("sleep_levels", 8'h0F, {4'h0, ready_level_out});
    sleep_req_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    vpp_fail <= 1'b1;
    issue(`FRBG_OP_PROGRAM, 2'h3);
    repeat (40) @(posedge ref_clk_in);
    chk("refused_level", 8'h08, {4'h0, ready_level_out & 4'h8});
    chk("vpp_on", 20'h1, {19'h0, vpp_en_out});
    note_q.push_back(8'h88);
    issue(`FRBG_OP_STATUS, 2'h3);
    repeat (2) @(posedge ref_clk_in);
    final_report();
  end
endmodule
bind frbg_host frbg_host_assertions chk_i (
  .ref_clk_in        (ref_clk_in),
  .nrst_in           (nrst_in),
  .ready_busy_n_in   (ready_busy_n_in),
  .irq_mask_in       (irq_mask_in),
  .irq_out           (irq_out),
  .merged_ready_out  (merged_ready_out),
  .ready_level_out   (ready_level_out),
  .chip_en_n_out     (chip_en_n_out),
  .write_en_n_out    (write_en_n_out),
  .flash_data_out    (flash_data_out),
  .flash_data_oe_out (flash_data_oe_out),
  .vpp_en_out        (vpp_en_out),
  .deep_sleep_n_out  (deep_sleep_n_out)
);
`default_nettype wire
